// ---- inc/qtimer_pkg.sv ----
// constants, field layouts and carrier types for the four-timer block
// Summary of operation
// - four timers each drive their own output pin when the count reaches the programmed reference value.
// - on reaching the reference each output either gives one active-low pulse or toggles its present level.
// - a timer can count the reference events of the timer before it, so two chained timers form one double-width timer.
// - each timer counts from the previous timer, the system clock, the system clock divided by sixteen, or its input pin.
// - there are four timer input pins in all, one belonging to each timer.
// - capture on a timer input triggers on the rising edge, the falling edge or both edges, as configured.
// - an external gate input can hold a timer's counting or restart the timer.
// - the first gate pin serves timer 1, timer 2 or both, and the second serves timer 3, timer 4 or both.
package qtimer_pkg;

  localparam int NUM_TIMERS = 4;
  localparam int CNT_W_DEF  = 16;
  localparam int ADDR_W_DEF = 8;
  localparam int CTRL_W     = 8;
  localparam int NUM_PINS   = 6;              // four timer inputs, two gates
  localparam int GATE_LO    = 4;              // index of low-pair gate pin
  localparam int GATE_HI    = 5;              // index of high-pair gate pin

  // divide-by-sixteen prescaler
  localparam int        DIV_W   = 4;
  localparam logic [3:0] DIV_LAST = 4'hF;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_REF    = 8'h04;
  localparam logic [7:0] OFF_CNT    = 8'h08;
  localparam logic [7:0] OFF_CAP    = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h40;
  localparam logic [7:0] OFF_MASK   = 8'h44;
  localparam logic [7:0] CH_AREA    = 8'h40;  // channel registers lie below this
  localparam int         CH_LSB     = 4;      // channel index field in address
  localparam logic [7:0] SUB_MASK   = 8'h0C;  // register-in-channel field

  // status and mask layout
  localparam int ST_REF_LSB = 0;
  localparam int ST_CAP_LSB = 4;
  localparam int ST_W       = 8;

  // reset values
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [31:0] REF_RST    = 32'hFFFFFFFF;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [7:0]  MASK_RST   = 8'h00;

  // count source codes
  localparam logic [1:0] SRC_CASCADE = 2'h0;
  localparam logic [1:0] SRC_SYSCLK  = 2'h1;
  localparam logic [1:0] SRC_DIV16   = 2'h2;
  localparam logic [1:0] SRC_PIN     = 2'h3;

  // capture edge codes
  localparam logic [1:0] CAP_OFF  = 2'h0;
  localparam logic [1:0] CAP_RISE = 2'h1;
  localparam logic [1:0] CAP_FALL = 2'h2;
  localparam logic [1:0] CAP_BOTH = 2'h3;

  // gate codes; the gate pin is asserted low
  localparam logic [1:0] GATE_OFF     = 2'h0;
  localparam logic [1:0] GATE_HOLD    = 2'h1;
  localparam logic [1:0] GATE_RESTART = 2'h2;

  typedef struct packed {
    logic [1:0] gate_mode;
    logic [1:0] cap_edge;
    logic       toggle;
    logic [1:0] src;
    logic       enable;
  } ctrl_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_evt_t;

endpackage

// ---- verilog/pin_edge_sync.sv ----
// two-stage synchroniser with edge detection for one timer pin
`timescale 1ns/100ps
module pin_edge_sync (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // raw pin and its clean level and edges
  input  wire logic                 pin,
  output qtimer_pkg::pin_evt_t      evt
);

  logic first;
  logic second;
  logic last;
  logic next_first;
  logic next_second;
  logic next_last;

  // only the second stage and its delayed copy feed the edge logic
  always_comb
  begin
    next_first  = pin;
    next_second = first;
    next_last   = second;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first  <= 1'b1;
      second <= 1'b1;
      last   <= 1'b1;
    end
    else
    begin
      first  <= next_first;
      second <= next_second;
      last   <= next_last;
    end
  end

  assign evt.level = second;
  assign evt.rise  = second & ~last;
  assign evt.fall  = ~second & last;

endmodule

// ---- verilog/quad_cascadable_timers.sv ----
// four cascadable timers with capture, gating, pin outputs and an APB register file
`timescale 1ns/100ps
module quad_cascadable_timers #(
  parameter int CNT_W  = qtimer_pkg::CNT_W_DEF,
  parameter int ADDR_W = qtimer_pkg::ADDR_W_DEF
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // timer input pins
  input  wire logic              timer_one_input_pin,
  input  wire logic              timer_two_input_pin,
  input  wire logic              timer_three_input_pin,
  input  wire logic              timer_four_input_pin,
  // gate pins, asserted low
  input  wire logic              gate_pin_timers_low_pair,
  input  wire logic              gate_pin_timers_high_pair,
  // timer output pins
  output logic                   timer_one_output_pin,
  output logic                   timer_two_output_pin,
  output logic                   timer_three_output_pin,
  output logic                   timer_four_output_pin,
  // interrupt
  output logic                   irq
);

  localparam int N = qtimer_pkg::NUM_TIMERS;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // refuse widths the register file cannot hold
  if (CNT_W < 2 || CNT_W > 32 || ADDR_W < 8)
  begin : g_bad_width
    $error("quad_cascadable_timers: CNT_W must be 2..32 and ADDR_W at least 8");
  end

  // pin synchronisers, one per input pin
  logic [qtimer_pkg::NUM_PINS-1:0] pin_raw;
  qtimer_pkg::pin_evt_t            pin_evt [qtimer_pkg::NUM_PINS];

  assign pin_raw = {gate_pin_timers_high_pair, gate_pin_timers_low_pair, timer_four_input_pin,
                    timer_three_input_pin, timer_two_input_pin, timer_one_input_pin};

  for (genvar p = 0; p < qtimer_pkg::NUM_PINS; p++)
  begin : g_pin
    pin_edge_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (pin_raw[p]),
      .evt     (pin_evt[p])
    );
  end

  // APB decode; one wait state so every answer leaves a flip-flop
  logic                      acc;
  logic                      in_ch;
  logic [1:0]                ch_sel;
  logic [7:0]                sub;
  logic                      hit_status;
  logic                      hit_mask;
  logic                      mapped;
  logic                      wr_status;
  logic                      wr_mask;
  logic [N-1:0]              wr_ctrl;
  logic [N-1:0]              wr_ref;
  logic [N-1:0]              wr_cnt;

  assign acc        = psel & penable & pready;
  assign in_ch      = paddr < ADDR_W'(qtimer_pkg::CH_AREA);
  assign ch_sel     = paddr[qtimer_pkg::CH_LSB +: 2];
  assign sub        = paddr[7:0] & qtimer_pkg::SUB_MASK;
  assign hit_status = paddr == ADDR_W'(qtimer_pkg::OFF_STATUS);
  assign hit_mask   = paddr == ADDR_W'(qtimer_pkg::OFF_MASK);
  assign mapped     = in_ch | hit_status | hit_mask;
  assign wr_status  = acc & pwrite & hit_status;
  assign wr_mask    = acc & pwrite & hit_mask;

  for (genvar w = 0; w < N; w++)
  begin : g_wdec
    logic sel_w;
    assign sel_w      = acc & pwrite & in_ch & (ch_sel == 2'(w));
    assign wr_ctrl[w] = sel_w & (sub == qtimer_pkg::OFF_CTRL);
    assign wr_ref[w]  = sel_w & (sub == qtimer_pkg::OFF_REF);
    assign wr_cnt[w]  = sel_w & (sub == qtimer_pkg::OFF_CNT);
  end

  // divide-by-sixteen prescaler, shared by all timers
  logic [qtimer_pkg::DIV_W-1:0] div_cnt;
  logic [qtimer_pkg::DIV_W-1:0] next_div_cnt;
  logic                         div_tick;

  always_comb
  begin
    next_div_cnt = div_cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= '0;
    else
      div_cnt <= next_div_cnt;
  end

  assign div_tick = div_cnt == qtimer_pkg::DIV_LAST;

  // per-timer state
  qtimer_pkg::ctrl_t ctrl    [N];
  logic [CNT_W-1:0]  cnt     [N];
  logic [CNT_W-1:0]  ref_val [N];
  logic [CNT_W-1:0]  cap     [N];
  logic [N-1:0]      tick;
  logic [N-1:0]      ref_evt;
  logic [N-1:0]      cap_evt;
  logic [N-1:0]      casc_evt;
  logic [N-1:0]      out_lvl;
  logic [N-1:0]      gate_on;

  for (genvar i = 0; i < N; i++)
  begin : g_ch
    localparam int PREV = (i + N - 1) % N;
    localparam int GP   = (i < 2) ? qtimer_pkg::GATE_LO : qtimer_pkg::GATE_HI;

    qtimer_pkg::ctrl_t next_ctrl;
    logic [CNT_W-1:0]  next_cnt;
    logic [CNT_W-1:0]  next_ref;
    logic [CNT_W-1:0]  next_cap;
    logic              next_casc;
    logic              next_out;
    logic              src_tick;
    logic              held;
    logic              restart;
    logic              edge_hit;

    // gate pin low means asserted; each timer opts in through its own gate mode
    assign gate_on[i] = ~pin_evt[GP].level;

    always_comb
    begin
      case (ctrl[i].src)
        qtimer_pkg::SRC_CASCADE: src_tick = casc_evt[PREV];
        qtimer_pkg::SRC_SYSCLK:  src_tick = 1'b1;
        qtimer_pkg::SRC_DIV16:   src_tick = div_tick;
        qtimer_pkg::SRC_PIN:     src_tick = pin_evt[i].rise;
        default:                 src_tick = 1'b0;
      endcase
      held     = (ctrl[i].gate_mode == qtimer_pkg::GATE_HOLD) & ~gate_on[i];
      restart  = (ctrl[i].gate_mode == qtimer_pkg::GATE_RESTART) & pin_evt[GP].fall;
      tick[i]  = ctrl[i].enable & src_tick & ~held & ~restart;
      ref_evt[i] = tick[i] & (cnt[i] == ref_val[i]);
      case (ctrl[i].cap_edge)
        qtimer_pkg::CAP_RISE: edge_hit = pin_evt[i].rise;
        qtimer_pkg::CAP_FALL: edge_hit = pin_evt[i].fall;
        qtimer_pkg::CAP_BOTH: edge_hit = pin_evt[i].rise | pin_evt[i].fall;
        default:              edge_hit = 1'b0;
      endcase
      cap_evt[i] = ctrl[i].enable & edge_hit;
    end

    // next values: software writes win over counting
    always_comb
    begin
      next_ctrl = wr_ctrl[i] ? qtimer_pkg::ctrl_t'(pwdata[qtimer_pkg::CTRL_W-1:0]) : ctrl[i];
      next_ref  = wr_ref[i] ? pwdata[CNT_W-1:0] : ref_val[i];
      next_cap  = cap_evt[i] ? cnt[i] : cap[i];
      next_casc = ref_evt[i];
      if (wr_cnt[i])
        next_cnt = pwdata[CNT_W-1:0];
      else if (restart & ctrl[i].enable)
        next_cnt = '0;
      else if (ref_evt[i])
        next_cnt = '0;
      else if (tick[i])
        next_cnt = cnt[i] + 1'b1;
      else
        next_cnt = cnt[i];
      // pulse mode idles high and dips for one cycle; toggle mode holds between matches
      if (ctrl[i].toggle)
        next_out = ref_evt[i] ? ~out_lvl[i] : out_lvl[i];
      else
        next_out = ~ref_evt[i];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ctrl[i]     <= qtimer_pkg::ctrl_t'(qtimer_pkg::CTRL_RST);
        ref_val[i]  <= qtimer_pkg::REF_RST[CNT_W-1:0];
        cnt[i]      <= '0;
        cap[i]      <= '0;
        casc_evt[i] <= 1'b0;
        out_lvl[i]  <= 1'b1;
      end
      else
      begin
        ctrl[i]     <= next_ctrl;
        ref_val[i]  <= next_ref;
        cnt[i]      <= next_cnt;
        cap[i]      <= next_cap;
        casc_evt[i] <= next_casc;
        out_lvl[i]  <= next_out;
      end
    end

    a_ref_clears_count: assert property (ref_evt[i] && !wr_cnt[i] |=> cnt[i] == '0)
      else $error("count not cleared after reference match");
    sequence s_pulse_low;
      !out_lvl[i] ##1 out_lvl[i];
    endsequence
    a_pulse_one_cycle: assert property (ref_evt[i] && !ctrl[i].toggle ##1 !ref_evt[i] |-> s_pulse_low)
      else $error("pulse output not one cycle low");
    a_toggle_flip: assert property (ref_evt[i] && ctrl[i].toggle |=> out_lvl[i] != $past(out_lvl[i]))
      else $error("toggle output did not change");
    a_cascade_tick: assert property (ctrl[i].enable && ctrl[i].src == qtimer_pkg::SRC_CASCADE
      && ctrl[i].gate_mode == qtimer_pkg::GATE_OFF && $past(ref_evt[PREV]) |-> tick[i])
      else $error("cascade event not counted");
    a_capture_edge: assert property (cap_evt[i] |=> cap[i] == $past(cnt[i]))
      else $error("capture did not latch count");
    a_gate_holds: assert property (ctrl[i].gate_mode == qtimer_pkg::GATE_HOLD && !gate_on[i]
      && !wr_cnt[i] |=> cnt[i] == $past(cnt[i]))
      else $error("count moved while gate closed");
  end

  assign timer_one_output_pin   = out_lvl[0];
  assign timer_two_output_pin   = out_lvl[1];
  assign timer_three_output_pin = out_lvl[2];
  assign timer_four_output_pin  = out_lvl[3];

  // sticky status: a hardware set in the cycle of a clear wins
  logic [qtimer_pkg::ST_W-1:0] status;
  logic [qtimer_pkg::ST_W-1:0] mask;
  logic [qtimer_pkg::ST_W-1:0] st_set;
  logic [qtimer_pkg::ST_W-1:0] st_clr;
  logic [qtimer_pkg::ST_W-1:0] next_status;
  logic [qtimer_pkg::ST_W-1:0] next_mask;
  logic                        next_irq;

  always_comb
  begin
    st_set = '0;
    st_set[qtimer_pkg::ST_REF_LSB +: N] = ref_evt;
    st_set[qtimer_pkg::ST_CAP_LSB +: N] = cap_evt;
    st_clr      = wr_status ? pwdata[qtimer_pkg::ST_W-1:0] : '0;
    next_status = (status & ~st_clr) | st_set;
    next_mask   = wr_mask ? pwdata[qtimer_pkg::ST_W-1:0] : mask;
    next_irq    = |(next_status & next_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= qtimer_pkg::STATUS_RST;
      mask   <= qtimer_pkg::MASK_RST;
      irq    <= 1'b0;
    end
    else
    begin
      status <= next_status;
      mask   <= next_mask;
      irq    <= next_irq;
    end
  end

  // read path and answer; read data is taken a cycle before pready rises
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  always_comb
  begin
    next_prdata  = prdata;
    next_pready  = psel & penable & ~pready;
    next_pslverr = pslverr;
    if (next_pready)
    begin
      next_pslverr = ~mapped;
      next_prdata  = '0;
      if (!pwrite)
      begin
        if (in_ch)
        begin
          case (sub)
            qtimer_pkg::OFF_CTRL: next_prdata = 32'(ctrl[ch_sel]);
            qtimer_pkg::OFF_REF:  next_prdata = 32'(ref_val[ch_sel]);
            qtimer_pkg::OFF_CNT:  next_prdata = 32'(cnt[ch_sel]);
            qtimer_pkg::OFF_CAP:  next_prdata = 32'(cap[ch_sel]);
            default:              next_prdata = '0;
          endcase
        end
        else if (hit_status)
          next_prdata = 32'(status);
        else if (hit_mask)
          next_prdata = 32'(mask);
      end
    end
    else if (!psel)
      next_pslverr = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  a_status_sticky: assert property (status[0] && !(wr_status && pwdata[0]) |=> status[0])
    else $error("status flag dropped without a clear");
  a_status_set: assert property (ref_evt[0] |=> status[qtimer_pkg::ST_REF_LSB])
    else $error("reference match did not set status");
  a_irq_level: assert property (irq == |(status & mask))
    else $error("interrupt does not follow masked status");
  a_div16_spacing: assert property (div_tick |=> !div_tick [*8])
    else $error("prescaler ticks too often");
  a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle after access");

endmodule

// ---- tb/pin_partner.sv ----
// board-side model driving the timer input pins and the two gate pins
`timescale 1ns/100ps
module pin_partner (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // requested pin levels and pace
  input  wire logic [5:0] want,
  input  wire logic       slow,
  // pins toward the timers: four inputs, low-pair gate, high-pair gate
  output logic      [5:0] pins
);
  logic [5:0] d1;
  logic [5:0] d2;
  logic [5:0] d3;

  // slow pace adds three cycles of board delay; reset leaves gates deasserted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      d1   <= 6'h3F;
      d2   <= 6'h3F;
      d3   <= 6'h3F;
      pins <= 6'h3F;
    end
    else
    begin
      d1   <= want;
      d2   <= d1;
      d3   <= d2;
      pins <= slow ? d3 : want;
    end
  end
endmodule

// ---- tb/quad_cascadable_timers_bench.sv ----
// self-checking bench for the four-timer block
`timescale 1ns/100ps
module quad_cascadable_timers_bench;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        slow    = 1'b0;
  logic        run4    = 1'b0;
  logic [5:0]  want    = 6'h3F;
  logic [5:0]  pins;
  logic [3:0]  touts;
  logic [31:0] rd;
  logic        er;
  int          pdiv    = 0;
  int          num_errors  = 0;
  int          check_count = 0;

  always #2.5 pclk = ~pclk;

  pin_partner board (.pclk(pclk), .presetn(presetn), .want(want), .slow(slow), .pins(pins));

  quad_cascadable_timers #(.CNT_W(16), .ADDR_W(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_one_input_pin(pins[0]), .timer_two_input_pin(pins[1]),
    .timer_three_input_pin(pins[2]), .timer_four_input_pin(pins[3]),
    .gate_pin_timers_low_pair(pins[4]), .gate_pin_timers_high_pair(pins[5]),
    .timer_one_output_pin(touts[0]), .timer_two_output_pin(touts[1]),
    .timer_three_output_pin(touts[2]), .timer_four_output_pin(touts[3]), .irq(irq));

  // board clock on timer four's input: one rising edge every six cycles
  always @(posedge pclk)
  begin
    if (run4)
    begin
      pdiv <= (pdiv == 2) ? 0 : pdiv + 1;
      if (pdiv == 2)
        want[3] <= ~want[3];
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one APB transfer; no cycle count assumed, only a bounded wait for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
      chk(32'h0, 32'h1);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] g, input logic [1:0] c, input logic t, input logic [1:0] s);
    qtimer_pkg::ctrl_t x;
    x = '{gate_mode: g, cap_edge: c, toggle: t, src: s, enable: 1'b1};
    return {24'h000000, x};
  endfunction

  function automatic logic [7:0] ra(input int t, input logic [7:0] off);
    return 8'(16 * t) + off;
  endfunction

  // cycles between two falling edges of one output pin
  task gap(input int i, output int n);
    logic p;
    repeat (2)
    begin
      n = 0;
      do
      begin
        p = touts[i];
        @(posedge pclk);
        #1;
        n++;
      end
      while (!(p === 1'b1 && touts[i] === 1'b0) && n < 600);
    end
  endtask

  task start(input int t, input logic [31:0] c, input int r);
    apb(1'b1, ra(t, qtimer_pkg::OFF_REF), 32'(r));
    apb(1'b1, ra(t, qtimer_pkg::OFF_CNT), 32'h0);
    apb(1'b1, ra(t, qtimer_pkg::OFF_CTRL), c);
  endtask

  task all_off();
    for (int t = 0; t < 4; t++)
      apb(1'b1, ra(t, qtimer_pkg::OFF_CTRL), 32'h0);
    apb(1'b1, qtimer_pkg::OFF_STATUS, 32'h000000FF);
  endtask

  task final_report();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog far beyond the thousand or so cycles the tests need
  initial
  begin
    #(5 * 60000);
    num_errors++;
    final_report();
  end

  initial
  begin
    int r;
    int r2;
    int n;
    logic e;
    r = $urandom(32'hf6b7);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped place that must be refused
    chk({28'h0, touts, irq}, 32'h1E);
    apb(1'b0, ra(0, qtimer_pkg::OFF_REF), 32'h0);
    chk(rd, 32'h0000FFFF);
    apb(1'b0, qtimer_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h48, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    // pulse mode, sticky status and masked interrupt
    apb(1'b1, qtimer_pkg::OFF_MASK, 32'h1);
    r = $urandom_range(1, 6);
    start(0, ctl(qtimer_pkg::GATE_OFF, qtimer_pkg::CAP_OFF, 1'b0, qtimer_pkg::SRC_SYSCLK), r);
    gap(0, n);
    chk(32'(n), 32'(r + 1));
    @(posedge pclk);
    #1;
    chk({31'h0, touts[0]}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ra(0, qtimer_pkg::OFF_CTRL), 32'h0);
    apb(1'b1, qtimer_pkg::OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, qtimer_pkg::OFF_STATUS, 32'h1);
    apb(1'b0, qtimer_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    // toggle mode: one full output cycle is two reference periods
    r = $urandom_range(0, 7);
    start(1, ctl(qtimer_pkg::GATE_OFF, qtimer_pkg::CAP_OFF, 1'b1, qtimer_pkg::SRC_SYSCLK), r);
    gap(1, n);
    chk(32'(n), 32'(2 * (r + 1)));
    all_off();
    // cascaded pair: timer two counts timer one's matches
    r  = $urandom_range(1, 4);
    r2 = $urandom_range(1, 4);
    start(1, ctl(qtimer_pkg::GATE_OFF, qtimer_pkg::CAP_OFF, 1'b0, qtimer_pkg::SRC_CASCADE), r2);
    start(0, ctl(qtimer_pkg::GATE_OFF, qtimer_pkg::CAP_OFF, 1'b0, qtimer_pkg::SRC_SYSCLK), r);
    gap(1, n);
    chk(32'(n), 32'((r + 1) * (r2 + 1)));
    all_off();
    // divided clock and pin clock sources
    r = $urandom_range(0, 2);
    start(2, ctl(qtimer_pkg::GATE_OFF, qtimer_pkg::CAP_OFF, 1'b0, qtimer_pkg::SRC_DIV16), r);
    gap(2, n);
    chk(32'(n), 32'(16 * (r + 1)));
    slow <= 1'b1;
    run4 <= 1'b1;
    start(3, ctl(qtimer_pkg::GATE_OFF, qtimer_pkg::CAP_OFF, 1'b0, qtimer_pkg::SRC_PIN), 0);
    gap(3, n);
    chk(32'(n), 32'h6);
    run4 <= 1'b0;
    all_off();
    // every capture code, both edges, prompt and slow board
    for (int c = 0; c < 4; c++)
    begin
      slow <= c[0];
      start(1, ctl(qtimer_pkg::GATE_OFF, 2'(c), 1'b0, qtimer_pkg::SRC_SYSCLK), 16'hFFFF);
      for (int lv = 0; lv < 2; lv++)
      begin
        apb(1'b1, qtimer_pkg::OFF_STATUS, 32'h000000FF);
        want[1] <= lv[0];
        repeat (12) @(posedge pclk);
        e = lv[0] ? (c == 1 || c == 3) : (c >= 2);
        apb(1'b0, qtimer_pkg::OFF_STATUS, 32'h0);
        chk(rd, {26'h0, e, 5'h0});
        // a capture must have latched a running count, never the reset zero
        if (e)
        begin
          apb(1'b0, ra(1, qtimer_pkg::OFF_CAP), 32'h0);
          chk({31'h0, rd > 32'h0 && rd < 32'h100}, 32'h1);
        end
      end
    end
    all_off();
    // hold and restart through each gate pin
    for (int t = 0; t < 4; t += 2)
    begin
      start(t, ctl(qtimer_pkg::GATE_HOLD, qtimer_pkg::CAP_OFF, 1'b0, qtimer_pkg::SRC_SYSCLK), 16'hFFFF);
      apb(1'b1, ra(t, qtimer_pkg::OFF_CNT), 32'h1234);
      repeat (5) @(posedge pclk);
      apb(1'b0, ra(t, qtimer_pkg::OFF_CNT), 32'h0);
      chk(rd, 32'h1234);
      want[4 + t / 2] <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(1'b0, ra(t, qtimer_pkg::OFF_CNT), 32'h0);
      chk({31'h0, rd > 32'h1234 && rd < 32'h1260}, 32'h1);
      want[4 + t / 2] <= 1'b1;
      apb(1'b1, ra(t, qtimer_pkg::OFF_CTRL),
          ctl(qtimer_pkg::GATE_RESTART, qtimer_pkg::CAP_OFF, 1'b0, qtimer_pkg::SRC_SYSCLK));
      apb(1'b1, ra(t, qtimer_pkg::OFF_CNT), 32'h5000);
      want[4 + t / 2] <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b0, ra(t, qtimer_pkg::OFF_CNT), 32'h0);
      chk({31'h0, rd < 32'h20}, 32'h1);
      want[4 + t / 2] <= 1'b1;
    end
    final_report();
  end
endmodule
